// ===== exec_pkg.sv
/*
 * Shared constants and types of the instruction execution block.
 * Assumes an APB bus with 32-bit data and byte addresses.
 */
package exec_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int DATA_W = 8;
  localparam int PC_W = 10;
  localparam int FILE_DEPTH = 64;
  localparam int FADDR_W = 6;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int WDT_W = 8;
  localparam int PRESC_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;
  localparam logic [7:0] ADDR_HIGH = 8'h10;
  localparam logic [7:0] ADDR_WDT = 8'h14;
  localparam logic [7:0] ADDR_FSEL = 8'h18;
  localparam logic [7:0] ADDR_FDATA = 8'h1c;
  localparam logic [7:0] ADDR_STACK = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int INSTR_IMM_LSB = 0;
  localparam int INSTR_FADDR_LSB = 8;
  localparam int INSTR_BIT_LSB = 16;
  localparam int INSTR_DEST_BIT = 19;
  localparam int INSTR_OPC_LSB = 24;
  localparam int ST_Z = 0;
  localparam int ST_DC = 1;
  localparam int ST_C = 2;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  localparam int ST_SKIP = 5;
  localparam int ST_BUSY = 6;
  localparam int HIGH_TABLE_HIGH_POINTER_LSB = 8;
  localparam int WDT_PRESC_LSB = 8;
  localparam int WDT_ASSIGN_BIT = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_TO_N = 1'b1;
  localparam logic RST_PD_N = 1'b1;
  localparam logic [PC_W-1:0] RST_PC = 10'h000;

  typedef enum logic [4:0] {
    NOP_OP, AND_IMMEDIATE_OP, BIT_CLEAR_OP, BIT_SET_OP, SKIP_IF_BIT_CLEAR_OP,
    SKIP_IF_BIT_SET_OP, CALL_OP, CALL_BY_ACCUMULATOR_OP, CLEAR_ACCUMULATOR_OP,
    CLEAR_REGISTER_OP, WATCHDOG_CLEAR_OP, COMPLEMENT_OP, COMPARE_OP,
    DECIMAL_ADJUST_OP, DECREMENT_OP, DECREMENT_SKIP_ZERO_OP, ADD_IMMEDIATE_OP
  } opcode_t;

  typedef enum logic [1:0] {PH_IDLE, PH_CALL} phase_t;

endpackage : exec_pkg

// ===== alu_if.sv
/*
 * Carrier between the execution core and its data path.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/1ps
interface alu_if;
  import exec_pkg::*;
  opcode_t op;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] fval;
  logic [DATA_W-1:0] imm;
  logic [2:0] bsel;
  logic c_in;
  logic dc_in;
  logic [DATA_W-1:0] res;
  logic z_out;
  logic c_out;
  logic dc_out;
  logic upd_z;
  logic upd_c;
  logic upd_dc;
  logic wr_acc;
  logic wr_file;
  logic skip;
  logic dest;
  modport core (output op, acc, fval, imm, bsel, c_in, dc_in, dest,
                input res, z_out, c_out, dc_out, upd_z, upd_c, upd_dc, wr_acc, wr_file, skip);
  modport alu (input op, acc, fval, imm, bsel, c_in, dc_in, dest,
               output res, z_out, c_out, dc_out, upd_z, upd_c, upd_dc, wr_acc, wr_file, skip);
endinterface : alu_if

// ===== exec_alu.sv
/*
 * Combinational data path: results, flag updates and skip decisions.
 * Assumes the core registers every result it takes.
 */
`timescale 1ns/1ps
module exec_alu
  import exec_pkg::*;
(
  alu_if.alu a
);

  logic [DATA_W:0] sum;
  logic [DATA_W-1:0] mask;
  logic [DATA_W:0] adj;

  always_comb begin
    mask = 8'h01 << a.bsel;
    sum = 9'h000;
    adj = 9'h000;
    a.res = a.acc;
    a.c_out = a.c_in;
    a.dc_out = a.dc_in;
    a.upd_z = 1'b0;
    a.upd_c = 1'b0;
    a.upd_dc = 1'b0;
    a.wr_acc = 1'b0;
    a.wr_file = 1'b0;
    a.skip = 1'b0;
    case (a.op)
      AND_IMMEDIATE_OP: begin
        a.res = a.acc & a.imm; // RULE1
        a.wr_acc = 1'b1;
        a.upd_z = 1'b1;
      end
      BIT_CLEAR_OP: begin
        a.res = a.fval & ~mask; // RULE2
        a.wr_file = 1'b1;
      end
      BIT_SET_OP: begin
        a.res = a.fval | mask; // RULE3
        a.wr_file = 1'b1;
      end
      SKIP_IF_BIT_CLEAR_OP: a.skip = ~a.fval[a.bsel]; // RULE4
      SKIP_IF_BIT_SET_OP: a.skip = a.fval[a.bsel]; // RULE5
      CLEAR_ACCUMULATOR_OP, CLEAR_REGISTER_OP: begin
        a.res = 8'h00; // RULE9
        a.wr_acc = (a.op == CLEAR_ACCUMULATOR_OP);
        a.wr_file = (a.op == CLEAR_REGISTER_OP);
        a.upd_z = 1'b1;
      end
      COMPLEMENT_OP: begin
        a.res = ~a.fval; // RULE11
        a.wr_acc = ~a.dest;
        a.wr_file = a.dest;
        a.upd_z = 1'b1;
      end
      COMPARE_OP: begin
        // Result only feeds flags; no write strobe is raised
        sum = {1'b0, a.fval} + {1'b0, ~a.acc} + 9'h001; // RULE12
        a.res = sum[DATA_W-1:0];
        a.c_out = sum[DATA_W]; // RULE16
        a.upd_z = 1'b1;
        a.upd_c = 1'b1;
      end
      DECIMAL_ADJUST_OP: begin
        adj = {1'b0, a.acc};
        if (a.dc_in || (a.acc[3:0] > 4'h9)) begin
          adj = adj + 9'h006;
        end
        if (a.c_in || (adj[7:4] > 4'h9) || adj[DATA_W]) begin
          adj = adj + 9'h060;
        end
        a.res = adj[DATA_W-1:0]; // RULE13
        a.c_out = a.c_in | adj[DATA_W];
        a.wr_acc = 1'b1;
        a.upd_c = 1'b1;
      end
      DECREMENT_OP, DECREMENT_SKIP_ZERO_OP: begin
        a.res = a.fval - 8'h01; // RULE15
        a.wr_acc = ~a.dest;
        a.wr_file = a.dest;
        a.upd_z = (a.op == DECREMENT_OP);
        a.skip = (a.op == DECREMENT_SKIP_ZERO_OP) && (a.fval == 8'h01); // RULE17
      end
      ADD_IMMEDIATE_OP: begin
        sum = {1'b0, a.acc} + {1'b0, a.imm};
        a.res = sum[DATA_W-1:0];
        a.c_out = sum[DATA_W]; // RULE16
        a.dc_out = ({1'b0, a.acc[3:0]} + {1'b0, a.imm[3:0]}) > 5'h0f;
        a.wr_acc = 1'b1;
        a.upd_z = 1'b1;
        a.upd_c = 1'b1;
        a.upd_dc = 1'b1;
      end
      default: a.res = a.acc;
    endcase
    a.z_out = (a.res == 8'h00);
  end

endmodule : exec_alu

// ===== mcu_instruction_execute.sv
/*
 * Instruction execution core reached over APB: software writes an
 * instruction word, the core executes it against its own accumulator,
 * file registers, program counter, stack and watchdog.
 * Assumes pclk at 50 MHz and a single APB master.
 */
`timescale 1ns/1ps

// Function
// RULE1: AND immediate into accumulator, zero flag, one cycle
// RULE2: Bit clear in file register, flags kept
// RULE3: Bit set in file register, flags kept
// RULE4: Skip next when tested bit is zero
// RULE5: Skip next when tested bit is one
// RULE6: Skipped instruction becomes NOP, two cycles total
// RULE7: Direct call pushes PC+1, loads buffer and immediate
// RULE8: Accumulator call pushes PC+1, loads pointer and accumulator
// RULE9: Clear accumulator or register, set zero flag
// RULE10: Watchdog clear zeroes counters, sets both status bits; a timeout in the same cycle still clears to_n here
// RULE11: Complement register to chosen destination, zero flag
// RULE12: Compare register minus accumulator, zero and carry
// RULE13: Decimal adjust accumulator, carry flag only
// RULE14: Software places adjust right after addition
// RULE15: Decrement register to chosen destination, zero flag
// RULE16: Carry means add carry or no borrow
// RULE17: Decrement, skip on zero result, flags kept
module mcu_instruction_execute
  import exec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic z;
    logic dc;
    logic c;
    logic to_n;
    logic pd_n;
    logic skip_pending;
    phase_t phase;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] call_target;
    logic [DATA_W-1:0] pc_high_buffer;
    logic [DATA_W-1:0] table_high_pointer;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [SP_W-1:0] sp;
    logic [FILE_DEPTH-1:0][DATA_W-1:0] files;
    logic [FADDR_W-1:0] file_sel;
    logic [31:0] instr;
    logic [WDT_W-1:0] wdt;
    logic [PRESC_W-1:0] presc;
    logic presc_to_wdt;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  state_t s_q;
  state_t s_d;

  alu_if a ();

  exec_alu u_alu (
    .a(a.alu)
  );

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic known_addr(input logic [7:0] addr);
    case (addr)
      ADDR_INSTR, ADDR_ACC, ADDR_STATUS, ADDR_PC, ADDR_HIGH,
      ADDR_WDT, ADDR_FSEL, ADDR_FDATA, ADDR_STACK: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction : known_addr

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      byte_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction : byte_merge

  logic busy;
  logic access;
  logic instr_wr;
  logic commit;
  logic [31:0] rd_val;
  logic [31:0] wr_val;
  logic [31:0] instr_word;
  opcode_t op_eff;
  logic [FADDR_W-1:0] faddr;
  logic [PC_W-1:0] pc_next;

  assign busy = (s_q.phase != PH_IDLE);
  assign access = psel & penable;
  assign instr_wr = pwrite && (paddr == ADDR_INSTR);
  // A second instruction waits while a two-cycle call is still running
  assign commit = access & s_q.pready;
  assign instr_word = byte_merge(s_q.instr, pwdata, pstrb);
  assign faddr = instr_word[INSTR_FADDR_LSB +: FADDR_W];
  assign pc_next = s_q.pc + 10'h001;

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      ADDR_INSTR: rd_val = s_q.instr;
      ADDR_ACC: rd_val[DATA_W-1:0] = s_q.acc;
      ADDR_STATUS: begin
        rd_val[ST_Z] = s_q.z;
        rd_val[ST_DC] = s_q.dc;
        rd_val[ST_C] = s_q.c;
        rd_val[ST_PD_N] = s_q.pd_n;
        rd_val[ST_TO_N] = s_q.to_n;
        rd_val[ST_SKIP] = s_q.skip_pending;
        rd_val[ST_BUSY] = busy;
      end
      ADDR_PC: rd_val[PC_W-1:0] = s_q.pc;
      ADDR_HIGH: begin
        rd_val[DATA_W-1:0] = s_q.pc_high_buffer;
        rd_val[HIGH_TABLE_HIGH_POINTER_LSB +: DATA_W] = s_q.table_high_pointer;
      end
      ADDR_WDT: begin
        rd_val[WDT_W-1:0] = s_q.wdt;
        rd_val[WDT_PRESC_LSB +: PRESC_W] = s_q.presc;
        rd_val[WDT_ASSIGN_BIT] = s_q.presc_to_wdt;
      end
      ADDR_FSEL: rd_val[FADDR_W-1:0] = s_q.file_sel;
      ADDR_FDATA: rd_val[DATA_W-1:0] = s_q.files[s_q.file_sel];
      ADDR_STACK: rd_val[SP_W-1:0] = s_q.sp;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Data path hookup
  // ****************************************
  always_comb begin
    // A skipped instruction is replaced by a NOP
    op_eff = s_q.skip_pending ? NOP_OP : opcode_t'(instr_word[INSTR_OPC_LSB +: 5]); // RULE6
    a.op = op_eff;
    a.acc = s_q.acc;
    a.fval = s_q.files[faddr];
    a.imm = instr_word[INSTR_IMM_LSB +: DATA_W];
    a.bsel = instr_word[INSTR_BIT_LSB +: 3];
    a.dest = instr_word[INSTR_DEST_BIT];
    a.c_in = s_q.c;
    a.dc_in = s_q.dc;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    wr_val = byte_merge(32'h0000_0000, pwdata, pstrb);

    // Bus handshake: one wait state, more for an instruction write while a call finishes
    s_d.pready = access && !s_q.pready && !(instr_wr && busy);
    s_d.pslverr = access && !s_q.pready && !known_addr(paddr);
    if (access && !s_q.pready) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
    end

    // Watchdog free run; prescaler only paces it when assigned
    if (s_q.presc_to_wdt) begin
      s_d.presc = s_q.presc + 8'h01;
    end
    if (!s_q.presc_to_wdt || (s_q.presc == '1)) begin
      s_d.wdt = s_q.wdt + 8'h01;
    end

    // Second cycle of a call loads the target
    if (s_q.phase == PH_CALL) begin
      s_d.pc = s_q.call_target; // RULE7 RULE8
      s_d.phase = PH_IDLE;
    end

    if (commit && pwrite && known_addr(paddr)) begin
      case (paddr)
        ADDR_INSTR: begin
          s_d.instr = instr_word;
          s_d.skip_pending = a.skip; // RULE4 RULE5 RULE17
          s_d.pc = pc_next;
          if (a.wr_acc) begin
            s_d.acc = a.res;
          end
          if (a.wr_file) begin
            s_d.files[faddr] = a.res;
          end
          if (a.upd_z) begin
            s_d.z = a.z_out; // RULE1 RULE9 RULE11 RULE12 RULE15
          end
          if (a.upd_c) begin
            s_d.c = a.c_out; // RULE12 RULE13 RULE16
          end
          if (a.upd_dc) begin
            s_d.dc = a.dc_out;
          end
          case (op_eff)
            CALL_OP, CALL_BY_ACCUMULATOR_OP: begin
              s_d.stack[s_q.sp] = pc_next; // RULE7 RULE8
              s_d.sp = s_q.sp + 3'h1;
              s_d.phase = PH_CALL;
              if (op_eff == CALL_OP) begin
                s_d.call_target = {s_q.pc_high_buffer[1:0], a.imm}; // RULE7
              end else begin
                s_d.call_target = {s_q.table_high_pointer[1:0], s_q.acc}; // RULE8
              end
            end
            WATCHDOG_CLEAR_OP: begin
              s_d.wdt = 8'h00; // RULE10
              if (s_q.presc_to_wdt) begin
                s_d.presc = 8'h00;
              end
              s_d.to_n = 1'b1;
              s_d.pd_n = 1'b1;
            end
            default: s_d.phase = s_d.phase;
          endcase
        end
        ADDR_ACC: s_d.acc = wr_val[DATA_W-1:0];
        ADDR_STATUS: begin
          s_d.z = wr_val[ST_Z];
          s_d.dc = wr_val[ST_DC];
          s_d.c = wr_val[ST_C];
        end
        ADDR_PC: s_d.pc = wr_val[PC_W-1:0];
        ADDR_HIGH: begin
          s_d.pc_high_buffer = wr_val[DATA_W-1:0];
          s_d.table_high_pointer = wr_val[HIGH_TABLE_HIGH_POINTER_LSB +: DATA_W];
        end
        ADDR_WDT: s_d.presc_to_wdt = wr_val[WDT_ASSIGN_BIT];
        ADDR_FSEL: s_d.file_sel = wr_val[FADDR_W-1:0];
        ADDR_FDATA: s_d.files[s_q.file_sel] = wr_val[DATA_W-1:0];
        default: s_d.acc = s_d.acc;
      endcase
    end

    // Timeout event wins over a clear in the same cycle
    if ((s_q.wdt == '1) && (s_d.wdt == 8'h00) && !(s_q.presc_to_wdt && (s_q.presc != '1))) begin
      s_d.to_n = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.to_n <= RST_TO_N;
      s_q.pd_n <= RST_PD_N;
      s_q.pc <= RST_PC;
      s_q.phase <= PH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;

endmodule : mcu_instruction_execute

// ===== mcu_instruction_execute_chk.sv
/*
 * Port checker for the instruction execution block.
 * Assumes one APB master keeping setup then access order.
 */
`timescale 1ns/1ps
module mcu_instruction_execute_chk
  import exec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  // ****************************************
  // Helper state
  // ****************************************
  logic clr_q;
  logic skp_q;
  logic [7:0] wcnt_q;
  wire logic done = psel && penable && pready;
  wire logic iw = done && pwrite && paddr == ADDR_INSTR && !pslverr;
  wire logic [4:0] opc = pwdata[28:24];
  wire logic rd_acc = pready && !pwrite && paddr == ADDR_ACC;
  wire logic rd_st = pready && !pwrite && paddr == ADDR_STATUS;
  wire logic mapped = paddr[1:0] == 2'h0 && paddr <= ADDR_STACK;

  // Skip kinds suppress checks: the next word may be discarded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_q <= 1'h0;
      skp_q <= 1'h0;
      wcnt_q <= 8'h00;
    end else begin
      if (done && pwrite) begin
        clr_q <= iw && opc == CLEAR_ACCUMULATOR_OP && !skp_q;
      end
      if (iw) begin
        skp_q <= opc == SKIP_IF_BIT_CLEAR_OP || opc == SKIP_IF_BIT_SET_OP || opc == DECREMENT_SKIP_ZERO_OP;
      end
      if (iw && opc == WATCHDOG_CLEAR_OP && !skp_q) begin
        wcnt_q <= 8'h01;
      end else if (wcnt_q != 8'h00 && wcnt_q != 8'hff) begin
        wcnt_q <= wcnt_q + 8'h01;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence access_start;
    psel && $rose(penable);
  endsequence
  sequence ready_seen;
    ##[1:3] pready;
  endsequence

  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_ready_bounded: assert property (access_start |-> ready_seen)
    else $error("ready late");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error response wrong");
  chk_write_rdata_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  chk_status_reserved: assert property (rd_st |-> prdata[31:7] == 25'h0)
    else $error("status reserved bits set");
  chk_clear_acc_zero: assert property (clr_q && rd_acc |-> prdata == 32'h0)
    else $error("accumulator not cleared");
  chk_clear_z_set: assert property (clr_q && rd_st |-> prdata[ST_Z] == 1'h1)
    else $error("zero flag not set by clear");
  chk_wdt_status_bits: assert property (rd_st && wcnt_q != 8'h00 && wcnt_q < 8'h64 |-> prdata[4:3] == 2'h3)
    else $error("status bits not set by watchdog clear");
endmodule : mcu_instruction_execute_chk

bind mcu_instruction_execute mcu_instruction_execute_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .prdata(prdata), .pslverr(pslverr));

// ===== mcu_instruction_execute_tb_top.sv
/*
 * Self-checking bench for the instruction execution block.
 * Assumes the block answers every APB access with pready.
 */
`timescale 1ns/1ps
module mcu_instruction_execute_tb_top;
  import exec_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic pready;
  logic pslverr;
  logic err;
  logic [31:0] prdata;
  logic [31:0] rd;
  int miscompares = 0;
  int n_tests = 0;

  mcu_instruction_execute u_mcu_instruction_execute (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

  initial begin
    forever #10 pclk = ~pclk;
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  // Waits for pready without a count of its own; the watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  // Status bit 4 moves with the watchdog and bit 3 stays set, so bits 4:3 are masked
  task automatic st(input logic [7:0] e);
    xfer(1'h0, ADDR_STATUS, 32'h0);
    chk({rd[31:5], 2'h0, rd[2:0]}, {24'h0, e});
  endtask : st

  task automatic ex(input opcode_t op, input logic d, input logic [2:0] b, input logic [5:0] f,
                    input logic [7:0] i);
    wr(ADDR_INSTR, {3'h0, op, 4'h0, d, b, 2'h0, f, i});
  endtask : ex

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_and;
    rdc(ADDR_STATUS, 32'h18);
    xfer(1'h0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(ADDR_STATUS, 32'h4);
    wr(ADDR_ACC, 32'h5a);
    ex(AND_IMMEDIATE_OP, 1'h0, 3'h0, 6'h00, 8'haf);
    rdc(ADDR_ACC, 32'h0a);
    st(8'h04);
    ex(AND_IMMEDIATE_OP, 1'h0, 3'h0, 6'h00, 8'h00);
    st(8'h05);
    rdc(ADDR_PC, 32'h2);
    $display("and test done");
  endtask : t_and

  task automatic t_bits;
    wr(ADDR_FSEL, 32'h3f);
    wr(ADDR_FDATA, 32'h5a);
    ex(BIT_CLEAR_OP, 1'h0, 3'h3, 6'h3f, 8'h00);
    rdc(ADDR_FDATA, 32'h52);
    ex(BIT_SET_OP, 1'h0, 3'h2, 6'h3f, 8'h00);
    ex(BIT_SET_OP, 1'h0, 3'h7, 6'h3f, 8'h00);
    rdc(ADDR_FDATA, 32'hd6);
    st(8'h05);
    $display("bit test done");
  endtask : t_bits

  task automatic t_skip;
    wr(ADDR_PC, 32'h100);
    ex(SKIP_IF_BIT_CLEAR_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    st(8'h25);
    ex(BIT_SET_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    rdc(ADDR_FDATA, 32'hd6);
    rdc(ADDR_PC, 32'h102);
    ex(SKIP_IF_BIT_SET_OP, 1'h0, 3'h1, 6'h3f, 8'h00);
    ex(BIT_SET_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    ex(SKIP_IF_BIT_CLEAR_OP, 1'h0, 3'h1, 6'h3f, 8'h00);
    ex(BIT_SET_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    rdc(ADDR_FDATA, 32'hd7);
    rdc(ADDR_PC, 32'h106);
    st(8'h05);
    $display("skip test done");
  endtask : t_skip

  task automatic t_call;
    wr(ADDR_HIGH, 32'h0201);
    ex(CALL_OP, 1'h0, 3'h0, 6'h00, 8'h34);
    rdc(ADDR_PC, 32'h134);
    rdc(ADDR_STACK, 32'h1);
    wr(ADDR_ACC, 32'h77);
    ex(CALL_BY_ACCUMULATOR_OP, 1'h0, 3'h0, 6'h00, 8'h00);
    rdc(ADDR_PC, 32'h277);
    rdc(ADDR_STACK, 32'h2);
    $display("call test done");
  endtask : t_call

  task automatic t_arith;
    wr(ADDR_STATUS, 32'h0);
    ex(CLEAR_ACCUMULATOR_OP, 1'h0, 3'h0, 6'h00, 8'h00);
    rdc(ADDR_ACC, 32'h0);
    st(8'h01);
    wr(ADDR_FDATA, 32'ha6);
    wr(ADDR_STATUS, 32'h0);
    ex(COMPLEMENT_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    rdc(ADDR_ACC, 32'h59);
    ex(COMPLEMENT_OP, 1'h1, 3'h0, 6'h3f, 8'h00);
    rdc(ADDR_FDATA, 32'h59);
    ex(CLEAR_REGISTER_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    rdc(ADDR_FDATA, 32'h0);
    st(8'h01);
    wr(ADDR_FDATA, 32'h34);
    wr(ADDR_ACC, 32'h12);
    wr(ADDR_STATUS, 32'h0);
    ex(COMPARE_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    st(8'h04);
    rdc(ADDR_ACC, 32'h12);
    wr(ADDR_ACC, 32'h35);
    ex(COMPARE_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    st(8'h00);
    wr(ADDR_ACC, 32'h38);
    ex(ADD_IMMEDIATE_OP, 1'h0, 3'h0, 6'h00, 8'h29);
    ex(DECIMAL_ADJUST_OP, 1'h0, 3'h0, 6'h00, 8'h00);
    rdc(ADDR_ACC, 32'h67);
    st(8'h02);
    wr(ADDR_ACC, 32'h99);
    ex(ADD_IMMEDIATE_OP, 1'h0, 3'h0, 6'h00, 8'h01);
    ex(DECIMAL_ADJUST_OP, 1'h0, 3'h0, 6'h00, 8'h00);
    rdc(ADDR_ACC, 32'h0);
    st(8'h04);
    wr(ADDR_FDATA, 32'h1);
    ex(DECREMENT_OP, 1'h1, 3'h0, 6'h3f, 8'h00);
    rdc(ADDR_FDATA, 32'h0);
    st(8'h05);
    ex(DECREMENT_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    rdc(ADDR_ACC, 32'hff);
    wr(ADDR_FDATA, 32'h1);
    ex(DECREMENT_SKIP_ZERO_OP, 1'h0, 3'h0, 6'h3f, 8'h00);
    st(8'h24);
    rdc(ADDR_ACC, 32'h0);
    ex(NOP_OP, 1'h0, 3'h0, 6'h00, 8'h00);
    $display("arithmetic test done");
  endtask : t_arith

  task automatic t_wdt;
    repeat (300) @(posedge pclk);
    xfer(1'h0, ADDR_STATUS, 32'h0);
    chk({30'h0, rd[4:3]}, 32'h1);
    ex(WATCHDOG_CLEAR_OP, 1'h0, 3'h0, 6'h00, 8'h00);
    xfer(1'h0, ADDR_STATUS, 32'h0);
    chk({30'h0, rd[4:3]}, 32'h3);
    wr(ADDR_WDT, 32'h10000);
    ex(WATCHDOG_CLEAR_OP, 1'h0, 3'h0, 6'h00, 8'h00);
    xfer(1'h0, ADDR_WDT, 32'h0);
    chk({23'h0, rd[16], rd[7:0]}, 32'h100);
    $display("watchdog test done");
  endtask : t_wdt

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    t_and;
    t_bits;
    t_skip;
    t_call;
    t_arith;
    t_wdt;
    end_of_test;
  end

  // Whole run is well under a thousand cycles
  initial begin
    #200000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test;
  end
endmodule : mcu_instruction_execute_tb_top
